// ### design/boid_map.vh
// Constants for the byte-op instruction decoder
// Summary of operation
// - Each instruction is one 14-bit word: opcode part plus operand fields.
// - Destination bit zero sends result to accumulator, one writes it back to register.
// - File address operand is 7 bits, reaching registers 0x00 to 0x7F.
// - Bit select operand picks one bit of the addressed 8-bit register.
// - Literal and control words carry an 8-bit or 11-bit constant.
// - One instruction cycle spans four oscillator periods.
// - One cycle normally; taken skip or program counter change adds a NOP cycle.
// - Every file-register instruction reads the register first, even pure writes like clear.
// - Don't-care opcode bits are ignored; decode is identical for zero or one.
// - OR of accumulator and register: opcode 00 0100, honours destination, zero flag only.
// - XOR of accumulator and register: opcode 00 0110, honours destination, zero flag only.
// - Decrement/increment-and-skip: 00 1011 and 00 1111, skip on zero result, no flags.
// - Rotate left through carry: opcode 00 1101, carry as ninth bit, carry only.
// - Rotate right through carry: opcode 00 1100, carry as ninth bit, carry only.
`ifndef BOID_MAP_VH
`define BOID_MAP_VH

`define BOID_INSTR_W      14
`define BOID_DATA_W       8
`define BOID_ADDR_W       7
`define BOID_LIT_W        11
`define BOID_Q_PER_CYCLE  4
`define BOID_OSC_PERIOD_NS 100
`define BOID_CYCLE_NS     (`BOID_Q_PER_CYCLE * `BOID_OSC_PERIOD_NS)

// Quarter phases within one instruction cycle
`define BOID_PH_Q1        2'h0
`define BOID_PH_Q2        2'h1
`define BOID_PH_Q3        2'h2
`define BOID_PH_Q4        2'h3

// Field positions
`define BOID_CLASS_MSB    13
`define BOID_CLASS_LSB    12
`define BOID_OP_MSB       11
`define BOID_OP_LSB       8
`define BOID_DEST_BIT     7
`define BOID_BIT_MSB      9
`define BOID_BIT_LSB      7

// Instruction classes
`define BOID_CLS_BYTE     2'h0
`define BOID_CLS_BIT      2'h1
`define BOID_CLS_CTRL     2'h2
`define BOID_CLS_LIT      2'h3

// Byte-oriented operation codes, also the arithmetic unit selects
`define BOID_OP_STORE_ACC 4'h0
`define BOID_OP_CLEAR     4'h1
`define BOID_OP_SUB       4'h2
`define BOID_OP_DEC       4'h3
`define BOID_OP_OR        4'h4
`define BOID_OP_AND       4'h5
`define BOID_OP_XOR       4'h6
`define BOID_OP_ADD       4'h7
`define BOID_OP_MOVE      4'h8
`define BOID_OP_COMP      4'h9
`define BOID_OP_INC       4'hA
`define BOID_OP_DEC_SKIP  4'hB
`define BOID_OP_ROT_RIGHT 4'hC
`define BOID_OP_ROT_LEFT  4'hD
`define BOID_OP_SWAP      4'hE
`define BOID_OP_INC_SKIP  4'hF

// Return and return-from-interrupt share bits [11:1]
`define BOID_RET_PATTERN  11'h004
`define BOID_NOP_WORD     14'h0000

`endif

// ### design/boid_alu.v
// Arithmetic and logic unit for the byte-op decoder
`timescale 1ns/100ps
`default_nettype none
`include "boid_map.vh"

module boid_alu #(
  parameter DATA_W = `BOID_DATA_W
) (
  input  wire [3:0]        op_i,
  input  wire [DATA_W-1:0] acc_i,
  input  wire [DATA_W-1:0] opnd_i,
  input  wire              carry_i,
  output reg  [DATA_W-1:0] result_o,
  output reg               carry_o,
  output reg               digit_carry_o,
  output wire              zero_o
);

  wire [DATA_W:0] add_full;
  wire [DATA_W:0] sub_full;
  wire [4:0]      add_nib;
  wire [4:0]      sub_nib;

  assign add_full = {1'b0, opnd_i} + {1'b0, acc_i};
  // Carry set means no borrow
  assign sub_full = {1'b0, opnd_i} + {1'b0, ~acc_i} + {{DATA_W{1'b0}}, 1'b1};
  assign add_nib  = {1'b0, opnd_i[3:0]} + {1'b0, acc_i[3:0]};
  assign sub_nib  = {1'b0, opnd_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;
  assign zero_o   = (result_o == {DATA_W{1'b0}});

  always @* begin
    result_o      = opnd_i;
    carry_o       = carry_i;
    digit_carry_o = 1'b0;
    case (op_i)
      `BOID_OP_STORE_ACC: result_o = acc_i;
      `BOID_OP_CLEAR:     result_o = {DATA_W{1'b0}};
      `BOID_OP_SUB: begin
        result_o      = sub_full[DATA_W-1:0];
        carry_o       = sub_full[DATA_W];
        digit_carry_o = sub_nib[4];
      end
      `BOID_OP_ADD: begin
        result_o      = add_full[DATA_W-1:0];
        carry_o       = add_full[DATA_W];
        digit_carry_o = add_nib[4];
      end
      `BOID_OP_DEC, `BOID_OP_DEC_SKIP: result_o = opnd_i - {{(DATA_W-1){1'b0}}, 1'b1};
      `BOID_OP_INC, `BOID_OP_INC_SKIP: result_o = opnd_i + {{(DATA_W-1){1'b0}}, 1'b1};
      `BOID_OP_OR:        result_o = opnd_i | acc_i;
      `BOID_OP_AND:       result_o = opnd_i & acc_i;
      `BOID_OP_XOR:       result_o = opnd_i ^ acc_i;
      `BOID_OP_COMP:      result_o = ~opnd_i;
      `BOID_OP_ROT_RIGHT: begin
        result_o = {carry_i, opnd_i[DATA_W-1:1]};
        carry_o  = opnd_i[0];
      end
      `BOID_OP_ROT_LEFT: begin
        result_o = {opnd_i[DATA_W-2:0], carry_i};
        carry_o  = opnd_i[DATA_W-1];
      end
      `BOID_OP_SWAP:      result_o = {opnd_i[3:0], opnd_i[DATA_W-1:4]};
      default:            result_o = opnd_i;
    endcase
  end

endmodule // boid_alu
`default_nettype wire

// ### design/boid_decoder.v
// Instruction decoder and four-phase sequencer for the 8-bit core
`timescale 1ns/100ps
`default_nettype none
`include "boid_map.vh"

module boid_decoder #(
  parameter INSTR_W = `BOID_INSTR_W,
  parameter DATA_W  = `BOID_DATA_W,
  parameter ADDR_W  = `BOID_ADDR_W,
  parameter LIT_W   = `BOID_LIT_W
) (
  input  wire               ref_clk_i,
  input  wire               resetn_i,
  input  wire [INSTR_W-1:0] instr_i,
  input  wire [DATA_W-1:0]  reg_rdata_i,
  output wire [1:0]         q_phase_o,
  output wire               nop_cycle_o,
  output wire [ADDR_W-1:0]  reg_addr_o,
  output wire               reg_rd_o,
  output wire               reg_wr_o,
  output wire [DATA_W-1:0]  reg_wdata_o,
  output wire [DATA_W-1:0]  acc_o,
  output wire               carry_o,
  output wire               digit_carry_o,
  output wire               zero_o,
  output wire               pc_step_o,
  output wire               pc_load_o,
  output wire               pc_push_o,
  output wire               pc_pop_o,
  output wire [LIT_W-1:0]   pc_target_o
);

  reg [1:0]         phase_reg;
  reg [INSTR_W-1:0] ir_reg;
  reg               nopc_reg;
  reg               rd_reg;
  reg               wr_reg;
  reg [ADDR_W-1:0]  addr_reg;
  reg [DATA_W-1:0]  wdata_reg;
  reg [DATA_W-1:0]  acc_reg;
  reg               c_reg;
  reg               dc_reg;
  reg               z_reg;
  reg               step_reg;
  reg               load_reg;
  reg               push_reg;
  reg               pop_reg;
  reg [LIT_W-1:0]   target_reg;

  // Field split of the held word
  wire [1:0]        cls   = ir_reg[`BOID_CLASS_MSB:`BOID_CLASS_LSB];
  wire [3:0]        bop   = ir_reg[`BOID_OP_MSB:`BOID_OP_LSB];
  wire              dsel  = ir_reg[`BOID_DEST_BIT];
  wire [ADDR_W-1:0] fadr  = ir_reg[ADDR_W-1:0];
  wire [2:0]        bsel  = ir_reg[`BOID_BIT_MSB:`BOID_BIT_LSB];
  wire [DATA_W-1:0] k8    = ir_reg[DATA_W-1:0];
  wire [LIT_W-1:0]  k11   = ir_reg[LIT_W-1:0];

  wire is_byte = (cls == `BOID_CLS_BYTE);
  wire is_bit  = (cls == `BOID_CLS_BIT);
  wire is_ctrl = (cls == `BOID_CLS_CTRL);
  wire is_lit  = (cls == `BOID_CLS_LIT);

  // Store and clear only name a register when bit 7 is set
  wire low_pair  = (bop == `BOID_OP_STORE_ACC) || (bop == `BOID_OP_CLEAR);
  wire byte_file = is_byte && (!low_pair || dsel);
  wire uses_file = byte_file || is_bit;
  // Bits 6:5 of the idle word and 6:0 of accumulator clear reach the address register, which is not read, and the return compare, which fails either way
  wire is_ret    = is_byte && (ir_reg[`BOID_OP_MSB:1] == `BOID_RET_PATTERN);
  wire is_retlw  = is_lit && (ir_reg[11:10] == 2'h1);

  // Literal operations reuse the byte unit codes
  reg  [3:0] lit_op;
  reg        lit_ok;
  always @* begin
    lit_ok = 1'b1;
    lit_op = `BOID_OP_MOVE;
    // Bits 9:8 of load/return and bit 8 of add/sub are don't-care
    if (ir_reg[11:10] != 2'h2) begin
      if (ir_reg[11:10] == 2'h3) begin
        lit_op = ir_reg[9] ? `BOID_OP_ADD : `BOID_OP_SUB;
      end else begin
        lit_op = `BOID_OP_MOVE;
      end
    end else if (ir_reg[9:8] == 2'h0) begin
      lit_op = `BOID_OP_OR;
    end else if (ir_reg[9:8] == 2'h1) begin
      lit_op = `BOID_OP_AND;
    end else if (ir_reg[9:8] == 2'h2) begin
      lit_op = `BOID_OP_XOR;
    end else begin
      lit_ok = 1'b0;
    end
  end

  wire [3:0]        alu_op  = is_lit ? lit_op : bop;
  wire [DATA_W-1:0] alu_b   = is_lit ? k8 : reg_rdata_i;
  wire [DATA_W-1:0] alu_res;
  wire              alu_c;
  wire              alu_dc;
  wire              alu_z;

  boid_alu #(
    .DATA_W (DATA_W)
  ) u_alu (
    .op_i          (alu_op),
    .acc_i         (acc_reg),
    .opnd_i        (alu_b),
    .carry_i       (c_reg),
    .result_o      (alu_res),
    .carry_o       (alu_c),
    .digit_carry_o (alu_dc),
    .zero_o        (alu_z)
  );

  // Bit-oriented path: one bit of the operand picked by the select field
  wire [DATA_W-1:0] bit_mask = {{(DATA_W-1){1'b0}}, 1'b1} << bsel;
  wire              bit_val  = |(reg_rdata_i & bit_mask);
  wire              bit_wr   = is_bit && !ir_reg[11];
  wire [DATA_W-1:0] bit_res  = ir_reg[10] ? (reg_rdata_i | bit_mask) : (reg_rdata_i & ~bit_mask);

  // Destination and flag selection
  wire file_wr = (byte_file && (dsel || low_pair)) || bit_wr;
  wire acc_wr  = (is_byte && !dsel && (bop != `BOID_OP_STORE_ACC)) || (is_lit && lit_ok);
  wire z_upd   = (is_byte && (bop >= `BOID_OP_CLEAR) && (bop <= `BOID_OP_INC) && (dsel || bop != `BOID_OP_STORE_ACC))
                 || (is_lit && lit_ok && ir_reg[11]);
  wire c_upd   = (is_byte && ((bop == `BOID_OP_ADD) || (bop == `BOID_OP_SUB) ||
                  (bop == `BOID_OP_ROT_LEFT) || (bop == `BOID_OP_ROT_RIGHT)))
                 || (is_lit && (ir_reg[11:10] == 2'h3));
  wire dc_upd  = (is_byte && ((bop == `BOID_OP_ADD) || (bop == `BOID_OP_SUB)))
                 || (is_lit && (ir_reg[11:10] == 2'h3));

  wire skip_byte = is_byte && ((bop == `BOID_OP_DEC_SKIP) || (bop == `BOID_OP_INC_SKIP)) && alu_z;
  wire skip_bit  = is_bit && ir_reg[11] && (bit_val == ir_reg[10]);
  wire pc_change = is_ctrl || is_ret || is_retlw;
  wire two_cycle = skip_byte || skip_bit || pc_change;

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_reg  <= `BOID_PH_Q1;
      ir_reg     <= `BOID_NOP_WORD;
      nopc_reg   <= 1'b0;
      rd_reg     <= 1'b0;
      wr_reg     <= 1'b0;
      addr_reg   <= {ADDR_W{1'b0}};
      wdata_reg  <= {DATA_W{1'b0}};
      acc_reg    <= {DATA_W{1'b0}};
      c_reg      <= 1'b0;
      dc_reg     <= 1'b0;
      z_reg      <= 1'b0;
      step_reg   <= 1'b0;
      load_reg   <= 1'b0;
      push_reg   <= 1'b0;
      pop_reg    <= 1'b0;
      target_reg <= {LIT_W{1'b0}};
    end else begin
      // Four oscillator periods make one instruction cycle
      phase_reg <= phase_reg + 2'h1;
      case (phase_reg)
        `BOID_PH_Q1: begin
          ir_reg   <= instr_i;
          wr_reg   <= 1'b0;
          step_reg <= 1'b0;
          load_reg <= 1'b0;
          push_reg <= 1'b0;
          pop_reg  <= 1'b0;
        end
        `BOID_PH_Q2: begin
          // Pure writes read too; nothing is read in a forced NOP cycle
          rd_reg   <= uses_file && !nopc_reg;
          addr_reg <= fadr;
        end
        `BOID_PH_Q3: begin
          rd_reg <= 1'b0;
        end
        default: begin
          // Data from the read arrives in this phase; all effects commit at its end
          if (nopc_reg) begin
            nopc_reg <= 1'b0;
            step_reg <= 1'b1;
          end else begin
            nopc_reg <= two_cycle;
            if (file_wr) begin
              wr_reg    <= 1'b1;
              wdata_reg <= bit_wr ? bit_res : alu_res;
            end
            if (acc_wr) begin
              acc_reg <= alu_res;
            end
            if (z_upd) begin
              z_reg <= alu_z;
            end
            if (c_upd) begin
              c_reg <= alu_c;
            end
            if (dc_upd) begin
              dc_reg <= alu_dc;
            end
            if (is_ctrl) begin
              load_reg   <= 1'b1;
              push_reg   <= !ir_reg[11];
              target_reg <= k11;
            end else if (is_ret || is_retlw) begin
              pop_reg <= 1'b1;
            end else begin
              step_reg <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  assign q_phase_o     = phase_reg;
  assign nop_cycle_o   = nopc_reg;
  assign reg_addr_o    = addr_reg;
  assign reg_rd_o      = rd_reg;
  assign reg_wr_o      = wr_reg;
  assign reg_wdata_o   = wdata_reg;
  assign acc_o         = acc_reg;
  assign carry_o       = c_reg;
  assign digit_carry_o = dc_reg;
  assign zero_o        = z_reg;
  assign pc_step_o     = step_reg;
  assign pc_load_o     = load_reg;
  assign pc_push_o     = push_reg;
  assign pc_pop_o      = pop_reg;
  assign pc_target_o   = target_reg;

endmodule // boid_decoder
`default_nettype wire

// ### test/boid_decoder_asserts.sv
// Port-level concurrent checks for the byte-op decoder
`timescale 1ns/100ps
`default_nettype none
module boid_decoder_asserts (
  input wire logic        ref_clk_i,
  input wire logic        resetn_i,
  input wire logic [13:0] instr_i,
  input wire logic [7:0]  reg_rdata_i,
  input wire logic [1:0]  q_phase_o,
  input wire logic        nop_cycle_o,
  input wire logic [6:0]  reg_addr_o,
  input wire logic        reg_rd_o,
  input wire logic        reg_wr_o,
  input wire logic [7:0]  reg_wdata_o,
  input wire logic [7:0]  acc_o,
  input wire logic        zero_o,
  input wire logic        pc_step_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  // Word taken this edge and not discarded
  wire take = (q_phase_o == 2'h0) && !nop_cycle_o;
  wire byte_op = take && (instr_i[13:12] == 2'h0);
  wire skip_op = byte_op && instr_i[11] && (instr_i[9:8] == 2'h3);

  chk_phase_walk: assert property (q_phase_o == 2'h0 |=> q_phase_o == 2'h1 ##1 q_phase_o == 2'h2 ##1 q_phase_o == 2'h3)
    else $error("quarter phase out of order");
  chk_read_addr: assert property (reg_rd_o |-> q_phase_o == 2'h2 && reg_addr_o == $past(instr_i[6:0], 2))
    else $error("read pulse in wrong phase or wrong address");
  chk_rmw_read: assert property (byte_op && instr_i[11:7] != 5'h00 && instr_i[11:7] != 5'h02 |-> ##2 reg_rd_o)
    else $error("file register not read first");
  chk_write_after: assert property (reg_wr_o |-> q_phase_o == 2'h0 && $past(reg_rd_o, 2))
    else $error("write without preceding read");
  chk_dest_select: assert property (byte_op && instr_i[11:9] != 3'h0 |-> ##4 reg_wr_o == $past(instr_i[7], 4))
    else $error("destination bit not honoured");
  chk_skip_taken: assert property (skip_op |-> ##4 nop_cycle_o == ($past(reg_rdata_i, 1) == ($past(instr_i[10], 4) ? 8'hFF : 8'h01)))
    else $error("skip decision wrong");
  chk_no_skip: assert property (byte_op && !(instr_i[11] && instr_i[9:8] == 2'h3) && instr_i[11:1] != 11'h004 |-> ##4 !nop_cycle_o)
    else $error("extra cycle without skip");
  chk_or_value: assert property (take && instr_i[13:7] == 7'h09 |-> ##4 reg_wdata_o == ($past(reg_rdata_i, 1) | $past(acc_o, 4)) && zero_o == (reg_wdata_o == 8'h00))
    else $error("or result or zero flag wrong");
  chk_xor_acc: assert property (take && instr_i[13:7] == 7'h0C |-> ##4 !reg_wr_o && acc_o == ($past(reg_rdata_i, 1) ^ $past(acc_o, 4)))
    else $error("xor into accumulator wrong");
  chk_discard: assert property (q_phase_o == 2'h0 && nop_cycle_o |-> ##2 !reg_rd_o ##2 !reg_wr_o && pc_step_o)
    else $error("discarded word had an effect");

  cov_skip: cover property ($rose(nop_cycle_o));
  cov_write: cover property (reg_wr_o);
  cov_or: cover property (take && instr_i[13:7] == 7'h09);
endmodule // boid_decoder_asserts

bind boid_decoder boid_decoder_asserts u_chk (.ref_clk_i, .resetn_i, .instr_i, .reg_rdata_i, .q_phase_o, .nop_cycle_o,
  .reg_addr_o, .reg_rd_o, .reg_wr_o, .reg_wdata_o, .acc_o, .zero_o, .pc_step_o);
`default_nettype wire

// ### test/boid_regfile_model.sv
// File register model answering the decoder's read and write pulses
`timescale 1ns/100ps
`default_nettype none
module boid_regfile_model (
  input  wire logic       ref_clk_i,
  input  wire logic [6:0] reg_addr_i,
  input  wire logic       reg_rd_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  output var  logic [7:0] reg_rdata_o
);
  logic [7:0] mem [0:127];
  initial reg_rdata_o = 8'h00;
  // Valid one cycle after a read only; inverted otherwise so stale data is caught
  always @(posedge ref_clk_i) begin
    reg_rdata_o <= reg_rd_i ? mem[reg_addr_i] : ~reg_rdata_o;
    if (reg_wr_i) begin
      mem[reg_addr_i] <= reg_wdata_i;
    end
  end
endmodule // boid_regfile_model
`default_nettype wire

// ### test/boid_decoder_tb_top.sv
// Self-checking bench for the byte-op decoder
`timescale 1ns/100ps
`default_nettype none
module boid_decoder_tb_top;
  logic        ref_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [13:0] instr_i = 14'h0000;
  wire  [7:0]  reg_rdata_i, reg_wdata_o, acc_o;
  wire  [1:0]  q_phase_o;
  wire         nop_cycle_o, reg_rd_o, reg_wr_o, carry_o, digit_carry_o, zero_o;
  wire         pc_step_o, pc_load_o, pc_push_o, pc_pop_o;
  wire  [6:0]  reg_addr_o;
  wire  [10:0] pc_target_o;
  int          errors = 0;
  int          samples_checked = 0;
  logic [7:0]  smem [0:127];
  logic [7:0]  eacc;
  logic        ec, edc, ez, pend;
  logic [3:0]  ops [0:7] = '{4'h4, 4'h6, 4'h7, 4'h2, 4'hB, 4'hF, 4'hD, 4'hC};

  boid_decoder DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .instr_i(instr_i), .reg_rdata_i(reg_rdata_i),
    .q_phase_o(q_phase_o), .nop_cycle_o(nop_cycle_o), .reg_addr_o(reg_addr_o), .reg_rd_o(reg_rd_o),
    .reg_wr_o(reg_wr_o), .reg_wdata_o(reg_wdata_o), .acc_o(acc_o), .carry_o(carry_o),
    .digit_carry_o(digit_carry_o), .zero_o(zero_o), .pc_step_o(pc_step_o), .pc_load_o(pc_load_o),
    .pc_push_o(pc_push_o), .pc_pop_o(pc_pop_o), .pc_target_o(pc_target_o));
  boid_regfile_model rf (.ref_clk_i(ref_clk_i), .reg_addr_i(reg_addr_o), .reg_rd_i(reg_rd_o),
    .reg_wr_i(reg_wr_o), .reg_wdata_i(reg_wdata_o), .reg_rdata_o(reg_rdata_i));

  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    if (errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Entered at a falling edge; the word is taken at the next rising edge
  task automatic exec(input logic [13:0] w);
    logic [7:0] f, r, m;
    logic [8:0] s;
    logic [4:0] h;
    logic       wr, sk, ld, pp;
    f = smem[w[6:0]];
    m = 8'h01 << w[9:7];
    r = f;
    wr = 1'b0;
    sk = 1'b0;
    ld = 1'b0;
    pp = 1'b0;
    if (pend) begin
      // Word fetched into a forced NOP cycle has no effect
    end else if (w[13:12] == 2'b01) begin
      wr = !w[11];
      r = w[10] ? (f | m) : (f & ~m);
      sk = w[11] && ((|(f & m)) == w[10]);
    end else if (w[13:12] == 2'b10) begin
      ld = 1'b1;
      sk = 1'b1;
    end else if (w[13:12] == 2'b11) begin
      // Only move, return-with-literal and the inclusive-or and exclusive-or literals are generated
      pp = (w[11:10] == 2'h1);
      sk = pp;
      r = w[7:0];
      if (w[11:10] == 2'h2) begin
        r = (w[9:8] == 2'h0) ? (eacc | w[7:0]) : (w[9:8] == 2'h1) ? (eacc & w[7:0]) : (eacc ^ w[7:0]);
        ez = (r == 8'h00);
      end
      eacc = r;
    end else begin
      s = (w[11:8] == 4'h2) ? {1'b0, f} + {1'b0, ~eacc} + 9'h001 : {1'b0, f} + {1'b0, eacc};
      h = (w[11:8] == 4'h2) ? {1'b0, f[3:0]} + {1'b0, ~eacc[3:0]} + 5'h01 : {1'b0, f[3:0]} + {1'b0, eacc[3:0]};
      case (w[11:8])
        4'h0: r = eacc;
        4'h1: r = 8'h00;
        4'h2, 4'h7: r = s[7:0];
        4'h4: r = eacc | f;
        4'h6: r = eacc ^ f;
        4'h3, 4'hB: r = f - 8'h01;
        4'hA, 4'hF: r = f + 8'h01;
        4'hD: {ec, r} = {f, ec};
        4'hC: {r, ec} = {ec, f};
        default: r = f;
      endcase
      if (w[11:8] == 4'h2 || w[11:8] == 4'h7) begin
        ec = s[8];
        edc = h[4];
      end
      if (w[11:8] inside {[4'h1:4'hA]}) begin
        ez = (r == 8'h00);
      end
      wr = w[7];
      if (!w[7] && w[11:8] != 4'h0) begin
        eacc = r;
      end
      sk = (w[11:8] inside {4'hB, 4'hF}) && r == 8'h00;
    end
    instr_i = w;
    repeat (4) @(negedge ref_clk_i);
    check(8'({nop_cycle_o, pc_step_o, reg_wr_o}), 8'({sk, !(ld || pp), wr}));
    check(8'({pc_load_o, pc_push_o, pc_pop_o}), 8'({ld, ld && !w[11], pp}));
    if (ld) begin
      check(pc_target_o[7:0], w[7:0]);
      check(8'(pc_target_o[10:8]), 8'(w[10:8]));
    end
    if (wr) begin
      check(reg_wdata_o, r);
      smem[w[6:0]] = r;
    end
    check(acc_o, eacc);
    check(8'({carry_o, digit_carry_o, zero_o}), 8'({ec, edc, ez}));
    pend = sk;
  endtask

  task automatic do_reset;
    resetn_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    check(acc_o, 8'h00);
    {eacc, ec, edc, ez, pend} = 12'h000;
    resetn_i = 1'b1;
  endtask

  // Legacy option and direction loads are never generated
  function automatic logic [13:0] rnd_word();
    // One word in four is a bit set, clear or test
    if ($urandom_range(3, 0) == 0) begin
      return {2'b01, 12'($urandom)};
    end
    return {2'b00, ops[$urandom_range(7, 0)], 8'($urandom)};
  endfunction

  initial begin
    void'($urandom(61970));
    for (int i = 0; i < 128; i++) begin
      smem[i] = (i == 16) ? 8'h01 : 8'($urandom);
      rf.mem[i] = smem[i];
    end
    do_reset;
    exec({7'h02, 7'($urandom)});
    exec({9'h000, 2'($urandom), 5'h00});
    exec(14'h01FF);
    exec(14'h0B90);
    exec(rnd_word());
    exec(14'h03FF);
    exec(14'h0FFF);
    exec(rnd_word());
    exec(14'h0080);
    exec(14'h2ABC);
    exec(rnd_word());
    exec(14'h2155);
    exec(rnd_word());
    exec(14'h3385);
    exec(14'h385A);
    exec(14'h3ADF);
    exec(14'h34C3);
    exec(rnd_word());
    repeat (150) exec(rnd_word());
    // Let the last write land before reset cuts it
    @(negedge ref_clk_i);
    do_reset;
    repeat (150) exec(rnd_word());
    end_sim;
  end

  initial begin
    repeat (3000) @(posedge ref_clk_i);
    errors++;
    end_sim;
  end
endmodule // boid_decoder_tb_top
`default_nettype wire
